/* rtl/cpiw_core.sv */
`timescale 1ns/1ps
`default_nettype none
module cpiw_core (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       osc_in,
  input  wire logic                       stop_wake,
  input  wire logic [31:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [31:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output var  logic                       sys_clk_q,
  output var  logic [cpiw_pkg::CPIW_PRE_W-1:0] periph_tap_q,
  output var  logic                       osc_out_q,
  output var  logic                       osc_in_hold_low_q,
  output var  logic                       feedback_en_q,
  output var  logic                       interval_irq_q,
  output var  logic                       watchdog_irq_q,
  output var  logic                       wd_reset_q,
  output var  logic                       stable_q
);
  import cpiw_pkg::*;

  // ****************************************
  // Oscillator and wake input synchronisers
  // ****************************************
  logic [2:0]            osc_sync_q;
  logic                  osc_lvl_q;
  logic                  osc_rise;
  logic [2:0]            wake_sync_q;
  logic                  wake_lvl_q;
  logic                  osc_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync_q  <= 3'h0;
      wake_sync_q <= 3'h0;
    end else begin
      osc_sync_q  <= {osc_sync_q[1:0], osc_in & osc_run};
      wake_sync_q <= {wake_sync_q[1:0], stop_wake};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_lvl_q  <= 1'b0;
      wake_lvl_q <= 1'b0;
    end else begin
      if (osc_sync_q[1] == osc_sync_q[2]) begin
        osc_lvl_q <= osc_sync_q[2];
      end
      if (wake_sync_q[1] == wake_sync_q[2]) begin
        wake_lvl_q <= wake_sync_q[2];
      end
    end
  end

  assign osc_rise = osc_sync_q[1] && osc_sync_q[2] && !osc_lvl_q;

  // ****************************************
  // Registers and state
  // ****************************************
  cpiw_ctrl_t            ctrl_q;
  logic                  iclr_q;
  logic [5:0]            cmp_q;
  logic [CPIW_PRE_W-1:0] pre_q;
  logic [CPIW_PRE_W-1:0] pre_d;
  logic [7:0]            icnt_q;
  logic [5:0]            wcnt_q;
  cpiw_state_t           state_q;
  logic                  tap_tick;
  logic                  ovf;
  logic                  wmatch;
  logic                  wr_fire;
  logic                  wr_ctrl;
  logic                  wr_cmp;
  logic [31:0]           wdat;

  assign osc_run = (state_q != CPIW_STOP);

  function automatic logic tap_edge(input logic [CPIW_PRE_W-1:0] now,
                                    input logic [CPIW_PRE_W-1:0] nxt,
                                    input logic [2:0] sel);
    int idx;
    idx = CPIW_TAP_BASE + int'(sel);
    return now[idx] && !nxt[idx];
  endfunction : tap_edge

  assign pre_d    = pre_q + {{(CPIW_PRE_W-1){1'b0}}, 1'b1};
  assign tap_tick = osc_rise && tap_edge(pre_q, pre_d, ctrl_q.sel);
  assign ovf      = tap_tick && (icnt_q == 8'hFF) && !iclr_q;
  assign wmatch   = ovf && ((wcnt_q + 6'h01) == cmp_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else if (osc_rise) begin
      pre_q <= pre_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_q <= 1'b0;
    end else if (osc_rise) begin
      sys_clk_q <= !sys_clk_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_tap_q <= '0;
    end else if (ctrl_q.pck_en) begin
      periph_tap_q <= pre_q;
    end
  end

  // ****************************************
  // Interval counter
  // ****************************************
  // free running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icnt_q <= 8'h00;
    end else if (iclr_q || (state_q == CPIW_STOP && wake_lvl_q)) begin
      icnt_q <= 8'h00;
    end else if (tap_tick) begin
      icnt_q <= icnt_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iclr_q <= 1'b0;
    end else begin
      iclr_q <= wr_ctrl && wdat[CPIW_BIT_ICLR];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_irq_q <= 1'b0;
    end else begin
      interval_irq_q <= ovf;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // counts overflows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_q <= 6'h00;
    end else if (wr_cmp && wdat[CPIW_BIT_WDCLR]) begin
      wcnt_q <= 6'h00;
    end else if (wmatch) begin
      wcnt_q <= 6'h00;
    end else if (ovf) begin
      wcnt_q <= wcnt_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_irq_q <= 1'b0;
      wd_reset_q     <= 1'b0;
    end else begin
      watchdog_irq_q <= wmatch && !ctrl_q.wd_mode;
      wd_reset_q     <= wmatch && ctrl_q.wd_mode;
    end
  end

  // ****************************************
  // Stop mode and stabilisation
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CPIW_STAB;
    end else begin
      case (state_q)
        CPIW_RUN: begin
          if (wr_ctrl && wdat[CPIW_BIT_STOP]) begin
            state_q <= CPIW_STOP;
          end
        end
        CPIW_STOP: begin
          if (wake_lvl_q) begin
            state_q <= CPIW_STAB;
          end
        end
        CPIW_STAB: begin
          if (ovf) begin
            state_q <= CPIW_RUN;
          end
        end
        default: begin
          state_q <= CPIW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_out_q         <= 1'b0;
      osc_in_hold_low_q <= 1'b0;
      feedback_en_q     <= 1'b1;
      stable_q          <= 1'b0;
    end else begin
      osc_out_q         <= (state_q == CPIW_STOP) ? 1'b1 : !osc_lvl_q;
      osc_in_hold_low_q <= (state_q == CPIW_STOP);
      feedback_en_q     <= (state_q != CPIW_STOP);
      stable_q          <= (state_q == CPIW_RUN);
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic                  aw_got_q;
  logic                  w_got_q;
  logic [3:0]            awa_q;
  logic [31:0]           wd_q;
  logic [3:0]            ws_q;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wdat    = wd_q;
  assign wr_ctrl = wr_fire && (awa_q == CPIW_ADDR_CTRL) && ws_q[0];
  assign wr_cmp  = wr_fire && (awa_q == CPIW_ADDR_CMP) && ws_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awa_q         <= 4'h0;
      wd_q          <= 32'h0;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CPIW_RESP_OK;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awa_q    <= s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q    <= s_axi_wdata;
        ws_q    <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awa_q == CPIW_ADDR_CTRL || awa_q == CPIW_ADDR_CMP) ? CPIW_RESP_OK : CPIW_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '{wd_mode: 1'b0, pck_en: 1'b1, sel: CPIW_SEL_RST};
      cmp_q  <= CPIW_CMP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.sel     <= wdat[CPIW_SEL_LSB +: 3];
        ctrl_q.pck_en  <= wdat[CPIW_BIT_PCKEN];
        ctrl_q.wd_mode <= wdat[CPIW_BIT_WDMODE];
      end
      if (wr_cmp) begin
        cmp_q <= wdat[5:0];
      end
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    case (s_axi_araddr[3:0])
      CPIW_ADDR_CTRL:   rd_val = {24'h0, icnt_q};
      CPIW_ADDR_CMP:    rd_val = {26'h0, cmp_q};
      CPIW_ADDR_STATUS: rd_val = {29'h0, stable_q, watchdog_irq_q, interval_irq_q};
      default:          rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= CPIW_RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= (s_axi_araddr[3:0] <= CPIW_ADDR_STATUS && s_axi_araddr[1:0] == 2'h0)
                        ? CPIW_RESP_OK : CPIW_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_iclr_self;
    @(posedge aclk) disable iff (!aresetn) iclr_q |=> !iclr_q && icnt_q == 8'h00;
  endproperty
  a_iclr_self: assert property (p_iclr_self) else $error("clear bit did not self clear");

  property p_ovf_irq;
    @(posedge aclk) disable iff (!aresetn) ovf |=> interval_irq_q && icnt_q == 8'h00;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("wrap without interrupt");

  property p_wd_reset;
    @(posedge aclk) disable iff (!aresetn) (wmatch && ctrl_q.wd_mode) |=> wd_reset_q && !watchdog_irq_q;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog match missed reset");

  property p_wd_irq;
    @(posedge aclk) disable iff (!aresetn) (wmatch && !ctrl_q.wd_mode) |=> watchdog_irq_q && wcnt_q == 6'h00;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("timer match missed interrupt");

  property p_wd_step;
    @(posedge aclk) disable iff (!aresetn) (!ovf && !wr_cmp) |=> $stable(wcnt_q);
  endproperty
  a_wd_step: assert property (p_wd_step) else $error("watchdog moved without overflow");

  property p_wd_clr;
    @(posedge aclk) disable iff (!aresetn) (wr_cmp && wdat[CPIW_BIT_WDCLR]) |=> wcnt_q == 6'h00;
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("watchdog clear failed");

  property p_tap_gate;
    @(posedge aclk) disable iff (!aresetn) !ctrl_q.pck_en |=> $stable(periph_tap_q);
  endproperty
  a_tap_gate: assert property (p_tap_gate) else $error("taps moved while gated");

  property p_stop_pins;
    @(posedge aclk) disable iff (!aresetn) (state_q == CPIW_STOP) |=> osc_out_q && osc_in_hold_low_q && !feedback_en_q;
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("stop pin state wrong");

  property p_stab_end;
    @(posedge aclk) disable iff (!aresetn) (state_q == CPIW_STAB && !ovf) |=> state_q != CPIW_RUN;
  endproperty
  a_stab_end: assert property (p_stab_end) else $error("left stabilisation early");

  c_ovf:   cover property (@(posedge aclk) disable iff (!aresetn) ovf);
  c_wdrst: cover property (@(posedge aclk) disable iff (!aresetn) wd_reset_q);
  c_wdirq: cover property (@(posedge aclk) disable iff (!aresetn) watchdog_irq_q);
  c_stop:  cover property (@(posedge aclk) disable iff (!aresetn) state_q == CPIW_STOP ##1 state_q == CPIW_STAB);

endmodule : cpiw_core
`default_nettype wire

/* rtl/cpiw_pkg.sv */
// Overview of operation
// - System clock is the oscillator clock divided by two.
// - Twelve-bit prescaler counts oscillator clock; every bit offered as a tap.
// - Peripheral clock enable, control bit 4, gates the taps; reset sets it.
// - Stop mode halts oscillation, output pin high, input held low, feedback off.
// - Eight-bit interval counter runs freely from a prescaler tap; only stop mode halts it.
// - Interval counter wrap from maximum to zero raises interval interrupt request.
// - Writing interval clear bit clears counter; bit returns to zero next cycle.
// - Three-bit select picks division by 8 up to 1024.
// - Reset sets all interval select bits to one.
// - Counter is read-only; write to its address updates clock control.
// - Oscillator stabilisation waits one full interval counter period.
// - Watchdog is six-bit counter compared with programmed compare value.
// - Control bit 5 picks interval timer or resetting watchdog.
// - Writing watchdog clear bit resets watchdog counter to zero.
// - Watchdog counter advances once per interval counter overflow.
// - After reset watchdog counts with compare value fifteen.
// - In watchdog mode a match puts the device in reset.
package cpiw_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] CPIW_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] CPIW_ADDR_CMP    = 4'h4;
  localparam logic [3:0] CPIW_ADDR_STATUS = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CPIW_SEL_LSB      = 0;
  localparam int CPIW_BIT_ICLR     = 3;
  localparam int CPIW_BIT_PCKEN    = 4;
  localparam int CPIW_BIT_WDMODE   = 5;
  localparam int CPIW_BIT_STOP     = 6;
  localparam int CPIW_BIT_WDCLR    = 6;
  localparam int CPIW_ST_IIRQ      = 0;
  localparam int CPIW_ST_WIRQ      = 1;
  localparam int CPIW_ST_STAB      = 2;

  // ****************************************
  // Reset values and widths
  // ****************************************
  localparam logic [2:0]  CPIW_SEL_RST  = 3'h7;
  localparam logic [5:0]  CPIW_CMP_RST  = 6'h0F;
  localparam int          CPIW_PRE_W    = 12;
  localparam int          CPIW_TAP_BASE = 2;
  localparam logic [1:0]  CPIW_RESP_OK  = 2'h0;
  localparam logic [1:0]  CPIW_RESP_ERR = 2'h2;

  typedef struct packed {
    logic       wd_mode;
    logic       pck_en;
    logic [2:0] sel;
  } cpiw_ctrl_t;

  typedef enum logic [1:0] {CPIW_RUN, CPIW_STOP, CPIW_STAB} cpiw_state_t;

endpackage : cpiw_pkg

/* verification/cpiw_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpiw_core_test;
  import cpiw_pkg::*;

  // ****************************************
  // Stimulus and design ports
  // ****************************************
  localparam int OSC_CYC = 4;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic                  osc_in = 1'b0;
  logic                  osc_ph = 1'b0;
  logic                  stop_wake = 1'b0;
  logic [31:0]           s_axi_awaddr = 32'h0;
  logic                  s_axi_awvalid = 1'b0;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_wvalid = 1'b0;
  logic                  s_axi_bready = 1'b0;
  logic [31:0]           s_axi_araddr = 32'h0;
  logic                  s_axi_arvalid = 1'b0;
  logic                  s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [31:0]           s_axi_rdata;
  logic                  sys_clk_q, osc_out_q, osc_in_hold_low_q, feedback_en_q;
  logic                  interval_irq_q, watchdog_irq_q, wd_reset_q, stable_q;
  logic [CPIW_PRE_W-1:0] periph_tap_q;
  logic [31:0]           rnd_q = 32'h6230;
  int                    cyc = 0;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  int                    m_sel = 7;
  int                    m_cmp = 15;

  cpiw_core u_dut (
    .aclk              (aclk),              .aresetn        (aresetn),        .osc_in        (osc_in),
    .stop_wake         (stop_wake),         .s_axi_awaddr   (s_axi_awaddr),   .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready     (s_axi_awready),     .s_axi_wdata    (s_axi_wdata),    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid      (s_axi_wvalid),      .s_axi_wready   (s_axi_wready),   .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid      (s_axi_bvalid),      .s_axi_bready   (s_axi_bready),   .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid     (s_axi_arvalid),     .s_axi_arready  (s_axi_arready),  .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp       (s_axi_rresp),       .s_axi_rvalid   (s_axi_rvalid),   .s_axi_rready  (s_axi_rready),
    .sys_clk_q         (sys_clk_q),         .periph_tap_q   (periph_tap_q),   .osc_out_q     (osc_out_q),
    .osc_in_hold_low_q (osc_in_hold_low_q), .feedback_en_q  (feedback_en_q),  .interval_irq_q (interval_irq_q),
    .watchdog_irq_q    (watchdog_irq_q),    .wd_reset_q     (wd_reset_q),     .stable_q      (stable_q)
  );

  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    osc_ph <= ~osc_ph;
    if (osc_ph) begin
      osc_in <= ~osc_in;
    end
  end

  // ****************************************
  // Model, checks and bus tasks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic int ovf();
    return (8 << m_sel) * 256 * OSC_CYC;
  endfunction : ovf

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0d range %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    rnd_q = xs(rnd_q);
    s_axi_awaddr <= {28'h0, a};
    s_axi_wdata <= {rnd_q[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= {28'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wait_pulse(input int which, output int t);
    logic hit;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      @(posedge aclk);
      hit = (which == 0) ? interval_irq_q : (which == 1) ? watchdog_irq_q : wd_reset_q;
    end
    t = cyc;
  endtask : wait_pulse

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  initial begin
    #500000;
    num_errors++;
    $display("unexpected at %0t: run timed out", $time);
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0]           d, c0;
    logic [1:0]            r;
    logic [CPIW_PRE_W-1:0] tp;
    logic                  sp;
    int                    n, t0, t1, t2;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CPIW_ADDR_CMP, d, r);
    chk(d, m_cmp, "compare reset");
    rd(CPIW_ADDR_STATUS, d, r);
    chk(d[CPIW_ST_STAB], 1'b0, "stable at reset");
    rd(4'hC, d, r);
    chk({r, d[29:0]}, {CPIW_RESP_ERR, 30'h0}, "unmapped read");
    wr(4'hC, 8'h55, r);
    chk(r, CPIW_RESP_ERR, "unmapped write");
    wr(CPIW_ADDR_CTRL, 8'h10, r);
    m_sel = 0;
    chk(r, CPIW_RESP_OK, "ctrl write");
    sp = sys_clk_q;
    n = 0;
    repeat (100 * OSC_CYC) begin
      @(posedge aclk);
      n += (sys_clk_q !== sp);
      sp = sys_clk_q;
    end
    chk_rng(n, 99, 101, "system clock toggles");
    tp = periph_tap_q;
    repeat (10 * OSC_CYC) @(posedge aclk);
    chk_rng(12'(periph_tap_q - tp), 9, 11, "prescaler advance");
    wr(CPIW_ADDR_CTRL, 8'h00, r);
    tp = periph_tap_q;
    repeat (100) @(posedge aclk);
    chk(periph_tap_q, tp, "taps frozen");
    wr(CPIW_ADDR_CTRL, 8'h10, r);
    @(posedge aclk);
    tp = periph_tap_q;
    repeat (10 * OSC_CYC) @(posedge aclk);
    chk_rng(12'(periph_tap_q - tp), 9, 11, "taps resume");
    for (int k = 0; k < 8; k++) begin
      wr(CPIW_ADDR_CTRL, 8'(8'h10 | k), r);
      m_sel = k;
      if (k < 5) begin
        rd(CPIW_ADDR_CTRL, c0, r);
        repeat (8 * (8 << k) * OSC_CYC) @(posedge aclk);
        rd(CPIW_ADDR_CTRL, d, r);
        chk_rng(8'(d - c0), 7, 9, "count rate per select");
      end
    end
    wr(CPIW_ADDR_CTRL, 8'h18, r);
    m_sel = 0;
    t0 = cyc;
    rd(CPIW_ADDR_CTRL, d, r);
    chk_rng(d, 0, 1, "count after clear");
    wait_pulse(0, t1);
    chk_rng(t1 - t0, ovf() - 40, ovf() + 40, "first wrap after clear");
    wait_pulse(0, t2);
    chk(t2 - t1, ovf(), "wrap period");
    wr(CPIW_ADDR_CMP, 8'h42, r);
    m_cmp = 2;
    rd(CPIW_ADDR_CMP, d, r);
    chk(d, m_cmp, "compare readback");
    wait_pulse(1, t1);
    wait_pulse(1, t2);
    chk(t2 - t1, m_cmp * ovf(), "watchdog period");
    rd(CPIW_ADDR_STATUS, d, r);
    chk(d[CPIW_ST_STAB], 1'b1, "stable after wrap");
    wr(CPIW_ADDR_CTRL, 8'h30, r);
    wr(CPIW_ADDR_CMP, 8'h41, r);
    t0 = cyc;
    wait_pulse(2, t1);
    chk(watchdog_irq_q, 1'b0, "no irq in reset mode");
    chk_rng(t1 - t0, 1, ovf() + 40, "reset on match");
    wr(CPIW_ADDR_CTRL, 8'h50, r);
    repeat (4) @(posedge aclk);
    chk({osc_out_q, osc_in_hold_low_q, feedback_en_q, stable_q}, 4'hC, "stop pins");
    stop_wake <= 1'b1;
    t0 = cyc;
    do @(posedge aclk); while (stable_q !== 1'b1);
    chk_rng(cyc - t0, ovf() - 40, ovf() + 40, "wake stabilisation");
    chk({osc_in_hold_low_q, feedback_en_q}, 2'h1, "pins after wake");
    stop_wake <= 1'b0;
    results();
  end

endmodule : cpiw_core_test
`default_nettype wire
